// File: rtl/ebzt_pkg.sv
package ebzt_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int EBZT_ZONES = 8;
    localparam int EBZT_ZONE_W = 3;
    localparam int EBZT_CNT_W = 4;
    localparam int EBZT_WS_W = 8;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] EBZT_OFS_TIMING0 = 8'h00;
    localparam logic [7:0] EBZT_OFS_CTRL = 8'h20;
    localparam logic [7:0] EBZT_OFS_STATUS = 8'h24;
    localparam int EBZT_CTRL_HALF_BIT = 0;
    localparam int EBZT_TIMING_W = 17;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [16:0] EBZT_TIMING_RST = 17'h1fff8;
    localparam logic EBZT_HALF_RST = 1'b0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // Per-zone timing settings, msb first
    typedef struct packed {
        logic [1:0] read_lead_count;
        logic [2:0] read_active_count;
        logic [1:0] read_trail_count;
        logic [1:0] write_lead_count;
        logic [2:0] write_active_count;
        logic [1:0] write_trail_count;
        logic double_period_sel;
        logic ready_enable;
        logic ready_async_sel;
    } ebzt_timing_type;

    typedef enum logic [1:0] {
        EBZT_IDLE = 2'b00,
        EBZT_LEAD = 2'b01,
        EBZT_ACTIVE = 2'b10,
        EBZT_TRAIL = 2'b11
    } ebzt_phase_type;

    // Engine state shown to software
    typedef struct packed {
        logic busy;
        ebzt_phase_type phase;
        logic [EBZT_WS_W-1:0] hw_wait_states;
    } ebzt_status_type;

endpackage

// File: rtl/ebzt_regs.sv
`timescale 1ns/10ps
module ebzt_regs
    import ebzt_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire ebzt_status_type status_in,
    output ebzt_timing_type [EBZT_ZONES-1:0] timing_out,
    output logic half_rate
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte-lane merge of write data into old contents
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic ack_q;
    logic [31:0] rdata_q;
    ebzt_timing_type [EBZT_ZONES-1:0] timing_q;
    logic half_q;

    wire req = wb_cyc_i && wb_stb_i && !ack_q;
    wire hit_timing = (wb_adr_i < EBZT_OFS_CTRL);
    wire hit_ctrl = (wb_adr_i[7:2] == EBZT_OFS_CTRL[7:2]);
    wire hit_status = (wb_adr_i[7:2] == EBZT_OFS_STATUS[7:2]);
    wire [EBZT_ZONE_W-1:0] zone_idx = wb_adr_i[EBZT_ZONE_W+1:2];
    wire [31:0] timing_word = {15'h0000, timing_q[zone_idx]};
    wire [31:0] ctrl_word = {31'h00000000, half_q};
    wire [31:0] status_word = {21'h000000, status_in};
    wire [31:0] timing_new = lane_merge(timing_word, wb_dat_i, wb_sel_i);
    wire [31:0] ctrl_new = lane_merge(ctrl_word, wb_dat_i, wb_sel_i);

    // Read mux, unmapped reads give zero
    wire [31:0] rd_mux = hit_timing ? timing_word :
                         hit_ctrl ? ctrl_word :
                         hit_status ? status_word : 32'h00000000;

    // ------------------------------------------------------------
    // Storage and one-cycle ack
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
            half_q <= EBZT_HALF_RST;
            for (int z = 0; z < EBZT_ZONES; z++) begin
                timing_q[z] <= EBZT_TIMING_RST;
            end
        end else begin
            ack_q <= req;
            if (req) begin
                rdata_q <= rd_mux;
            end
            if (req && wb_we_i && hit_timing) begin
                timing_q[zone_idx] <= timing_new[EBZT_TIMING_W-1:0];
            end
            if (req && wb_we_i && hit_ctrl) begin
                half_q <= ctrl_new[EBZT_CTRL_HALF_BIT];
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign timing_out = timing_q;
    assign half_rate = half_q;

endmodule

// File: rtl/ebzt_top.sv
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module ebzt_top
    import ebzt_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic acc_req,
    input wire logic acc_write,
    input wire logic [EBZT_ZONE_W-1:0] acc_zone,
    output logic acc_ready,
    output logic acc_done,
    input wire logic ext_ready_in,
    output logic [EBZT_ZONES-1:0] zone_select_n,
    output logic ext_read_strobe_n,
    output logic ext_write_strobe_n
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Phase length in ticks, optionally doubled
    function automatic logic [EBZT_CNT_W-1:0] scale_len(
        input logic [2:0] count,
        input logic dbl
    );
        logic [EBZT_CNT_W-1:0] ext;
        ext = {1'b0, count};
        return dbl ? EBZT_CNT_W'(ext << 1) : ext;
    endfunction

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    ebzt_timing_type [EBZT_ZONES-1:0] timing_all;
    ebzt_status_type status;
    logic half_rate;

    ebzt_regs u_regs (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .status_in(status),
        .timing_out(timing_all),
        .half_rate(half_rate)
    );

    // ------------------------------------------------------------
    // Interface timing clock enable
    // ------------------------------------------------------------
    logic div_q;

    // Full rate or every other system cycle
    wire tick = !half_rate || div_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 1'b0;
        end else begin
            div_q <= !div_q;
        end
    end

    // ------------------------------------------------------------
    // Ready pin synchroniser
    // ------------------------------------------------------------
    logic rdy_meta_q;
    logic rdy_sync_q;
    logic rdy_late_q;

    // Two flops, plus a third stage for the asynchronous mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdy_meta_q <= 1'b1;
            rdy_sync_q <= 1'b1;
            rdy_late_q <= 1'b1;
        end else begin
            rdy_meta_q <= ext_ready_in;
            rdy_sync_q <= rdy_meta_q;
            rdy_late_q <= rdy_sync_q;
        end
    end

    // ------------------------------------------------------------
    // Request capture
    // ------------------------------------------------------------
    ebzt_phase_type phase_q;
    ebzt_phase_type phase_d;
    logic pend_q;
    logic write_q;
    logic [EBZT_ZONE_W-1:0] zone_q;
    ebzt_timing_type cfg_q;

    // Accept only while the engine is idle and nothing waits
    assign acc_ready = (phase_q == EBZT_IDLE) && !pend_q;
    wire take = acc_req && acc_ready;

    // Settings of the addressed zone are frozen for the access
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            write_q <= 1'b0;
            zone_q <= '0;
            cfg_q <= EBZT_TIMING_RST;
        end else if (take) begin
            write_q <= acc_write;
            zone_q <= acc_zone;
            cfg_q <= timing_all[acc_zone];
        end
    end

    // ------------------------------------------------------------
    // Phase lengths of the captured access
    // ------------------------------------------------------------
    wire [2:0] lead_raw = write_q ? {1'b0, cfg_q.write_lead_count}
                                  : {1'b0, cfg_q.read_lead_count};
    wire [2:0] act_raw = write_q ? cfg_q.write_active_count
                                 : cfg_q.read_active_count;
    wire [2:0] trail_raw = write_q ? {1'b0, cfg_q.write_trail_count}
                                   : {1'b0, cfg_q.read_trail_count};

    // Lead, active and trail all scale; active adds one base tick
    wire [EBZT_CNT_W-1:0] lead_len =
        scale_len(lead_raw, cfg_q.double_period_sel);
    wire [EBZT_CNT_W-1:0] act_len =
        scale_len(act_raw, cfg_q.double_period_sel);
    wire [EBZT_CNT_W-1:0] trail_len =
        scale_len(trail_raw, cfg_q.double_period_sel);

    // No legality check: zero lead or trail lengths just skip the phase
    wire lead_skip = (lead_len == '0);
    wire trail_skip = (trail_len == '0);

    // ------------------------------------------------------------
    // Wait state decision
    // ------------------------------------------------------------
    logic [EBZT_CNT_W-1:0] cnt_q;
    logic [EBZT_CNT_W-1:0] cnt_d;
    logic [EBZT_WS_W-1:0] ws_q;

    // Sampling path picked per zone
    wire rdy_seen = cfg_q.ready_async_sel ? rdy_late_q
                                          : rdy_sync_q;
    // Ready is ignored when the zone does not use it
    wire hold_off = cfg_q.ready_enable && !rdy_seen;
    wire cnt_end = (cnt_q == '0);
    wire act_extend = (phase_q == EBZT_ACTIVE) && cnt_end && hold_off;
    wire ws_full = (ws_q == {EBZT_WS_W{1'b1}});

    // ------------------------------------------------------------
    // Phase sequencer, next state
    // ------------------------------------------------------------
    always_comb begin
        phase_d = phase_q;
        cnt_d = cnt_q;
        case (phase_q)
            EBZT_IDLE: begin
                if (pend_q) begin
                    // Lead first, or straight to active on zero lead
                    if (lead_skip) begin
                        phase_d = EBZT_ACTIVE;
                        cnt_d = act_len;
                    end else begin
                        phase_d = EBZT_LEAD;
                        cnt_d = lead_len - 1'b1;
                    end
                end
            end
            EBZT_LEAD: begin
                if (cnt_end) begin
                    phase_d = EBZT_ACTIVE;
                    cnt_d = act_len;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            EBZT_ACTIVE: begin
                if (act_extend) begin
                    cnt_d = cnt_q;
                end else if (cnt_end) begin
                    phase_d = trail_skip ? EBZT_IDLE : EBZT_TRAIL;
                    cnt_d = trail_len - 1'b1;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            EBZT_TRAIL: begin
                if (cnt_end) begin
                    phase_d = EBZT_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: begin
                phase_d = EBZT_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer state, phase and count advanced on timing ticks only
    // ------------------------------------------------------------
    wire start = tick && (phase_q == EBZT_IDLE) && pend_q;
    wire finish = tick && (phase_q != EBZT_IDLE) && (phase_d == EBZT_IDLE);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= EBZT_IDLE;
            cnt_q <= '0;
            pend_q <= 1'b0;
        end else begin
            if (take) begin
                pend_q <= 1'b1;
            end else if (start) begin
                pend_q <= 1'b0;
            end
            if (tick) begin
                phase_q <= phase_d;
                cnt_q <= cnt_d;
            end
        end
    end

    // Wait states of the current or last access
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ws_q <= '0;
        end else if (start) begin
            ws_q <= '0;
        end else if (tick && act_extend && !ws_full) begin
            ws_q <= ws_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    logic [EBZT_ZONES-1:0] cs_n_q;
    logic rd_n_q;
    logic wr_n_q;
    logic done_q;

    // Select covers the whole access, strobe only active
    wire in_access = (phase_d != EBZT_IDLE);
    wire in_active = (phase_d == EBZT_ACTIVE);
    wire [EBZT_ZONES-1:0] zone_onehot = EBZT_ZONES'(1) << zone_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cs_n_q <= '1;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else if (tick) begin
            cs_n_q <= in_access ? ~zone_onehot : '1;
            rd_n_q <= !(in_active && !write_q);
            wr_n_q <= !(in_active && write_q);
        end
    end

    // Completion pulse, one system cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
        end else begin
            done_q <= finish;
        end
    end

    assign zone_select_n = cs_n_q;
    assign ext_read_strobe_n = rd_n_q;
    assign ext_write_strobe_n = wr_n_q;
    assign acc_done = done_q;

    // ------------------------------------------------------------
    // Status to software
    // ------------------------------------------------------------
    assign status.busy = !acc_ready;
    assign status.phase = phase_q;
    assign status.hw_wait_states = ws_q;

endmodule

// File: testbench/ebzt_far_model.sv
`timescale 1ns/10ps
module ebzt_far_model
    import ebzt_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [EBZT_ZONES-1:0] zone_select_n,
    input wire logic ext_read_strobe_n,
    input wire logic ext_write_strobe_n,
    input wire logic [7:0] stall_len,
    output logic ext_ready_in
);
    logic [7:0] left_q = 8'h00;
    logic desel_q = 1'b1;
    logic idle_q = 1'b0;
    wire desel = &zone_select_n;
    wire fall = desel_q & ~desel;

    // Stall span starts where the select falls, so that the slower
    // three-flop ready path still sees it before active ends
    always @(posedge clk_sys) begin
        desel_q <= desel;
        idle_q <= ~idle_q;
        if (fall)
            left_q <= stall_len;
        else if (left_q != 8'h00)
            left_q <= left_q - 8'h01;
    end
    // Unselected: line wanders, so no stale level passes for ready
    assign ext_ready_in = (&zone_select_n) ? idle_q :
        fall ? (stall_len == 8'h00) : (left_q == 8'h00);
endmodule

// File: testbench/ebzt_top_sva.sv
`timescale 1ns/10ps
module ebzt_top_sva
    import ebzt_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic acc_req,
    input wire logic acc_write,
    input wire logic [EBZT_ZONE_W-1:0] acc_zone,
    input wire logic acc_ready,
    input wire logic acc_done,
    input wire logic [EBZT_ZONES-1:0] zone_select_n,
    input wire logic ext_read_strobe_n,
    input wire logic ext_write_strobe_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic wr_q;
    logic [EBZT_ZONE_W-1:0] zone_q;

    // Direction and zone of the access in flight
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= 1'b0;
            zone_q <= '0;
        end else if (acc_req && acc_ready) begin
            wr_q <= acc_write;
            zone_q <= acc_zone;
        end
    end

    // ------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------
    sequence s_take;
        acc_req && acc_ready;
    endsequence
    sequence s_pins_idle;
        zone_select_n == 8'hff && ext_read_strobe_n && ext_write_strobe_n;
    endsequence
    property p_take_busy;
        s_take |=> !acc_ready;
    endproperty
    property p_cs_start;
        s_take |-> ##[1:4] (zone_select_n != 8'hff);
    endproperty
    property p_done_idle;
        acc_done |-> s_pins_idle;
    endproperty
    property p_ready_idle;
        acc_ready |-> s_pins_idle;
    endproperty
    property p_done_pulse;
        acc_done |=> !acc_done;
    endproperty
    property p_zone_match;
        zone_select_n != 8'hff |-> zone_select_n == ~(8'h01 << zone_q);
    endproperty
    property p_strobe_in_cs;
        !(ext_read_strobe_n && ext_write_strobe_n) |->
            zone_select_n != 8'hff && (ext_read_strobe_n || ext_write_strobe_n);
    endproperty
    property p_strobe_dir;
        (!ext_read_strobe_n |-> !wr_q) and (!ext_write_strobe_n |-> wr_q);
    endproperty
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty

    a_take_busy: assert property (p_take_busy) else $error("ready held");
    a_cs_start: assert property (p_cs_start) else $error("no select");
    a_done_idle: assert property (p_done_idle) else $error("pins busy");
    a_ready_idle: assert property (p_ready_idle) else $error("idle pins");
    a_done_pulse: assert property (p_done_pulse) else $error("done long");
    a_zone_match: assert property (p_zone_match) else $error("bad zone");
    a_strobe_in_cs: assert property (p_strobe_in_cs) else $error("strobe");
    a_strobe_dir: assert property (p_strobe_dir) else $error("direction");
    a_ack_next: assert property (p_ack_next) else $error("no ack");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
endmodule

bind ebzt_top ebzt_top_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .acc_req(acc_req), .acc_write(acc_write), .acc_zone(acc_zone),
    .acc_ready(acc_ready), .acc_done(acc_done),
    .zone_select_n(zone_select_n), .ext_read_strobe_n(ext_read_strobe_n),
    .ext_write_strobe_n(ext_write_strobe_n));

// File: testbench/ebzt_top_test.sv
`timescale 1ns/10ps
module ebzt_top_test
    import ebzt_pkg::*;
    ;
    logic clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic acc_req, acc_write, acc_ready, acc_done, ext_ready_in;
    logic ext_read_strobe_n, ext_write_strobe_n;
    logic [7:0] wb_adr_i, stall_len;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rdat;
    logic [EBZT_ZONE_W-1:0] acc_zone;
    logic [EBZT_ZONES-1:0] zone_select_n, cs_seen;
    int n_errors, comparisons, lead_n, act_n, trail_n, dir_n;

    ebzt_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .acc_req(acc_req), .acc_write(acc_write),
        .acc_zone(acc_zone), .acc_ready(acc_ready), .acc_done(acc_done),
        .ext_ready_in(ext_ready_in), .zone_select_n(zone_select_n),
        .ext_read_strobe_n(ext_read_strobe_n),
        .ext_write_strobe_n(ext_write_strobe_n));
    ebzt_far_model u_far (.clk_sys(clk_sys), .zone_select_n(zone_select_n),
        .ext_read_strobe_n(ext_read_strobe_n),
        .ext_write_strobe_n(ext_write_strobe_n), .stall_len(stall_len),
        .ext_ready_in(ext_ready_in));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Phase lengths measured at the pins
    always @(posedge clk_sys) begin
        if (zone_select_n != 8'hff) begin
            cs_seen = ~zone_select_n;
            if (!ext_read_strobe_n || !ext_write_strobe_n) begin
                act_n++;
                dir_n = ext_read_strobe_n ? 2 : 1;
            end else if (act_n > 0)
                trail_n++;
            else
                lead_n++;
        end
    end

    task automatic close_out();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #(50 * 40000);
        n_errors++;
        close_out();
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_sel_i <= 4'hf;
        wb_adr_i <= a;
        wb_dat_i <= d;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        rdat = wb_dat_o;
        chk("ack", 1, wb_ack_o);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys);
    endtask

    function automatic logic [31:0] tim(input logic [1:0] rl,
        input logic [2:0] ra, input logic [1:0] rt, wl, input logic [2:0] wa,
        input logic [1:0] wt, input logic [2:0] m);
        return {15'h0000, rl, ra, rt, wl, wa, wt, m};
    endfunction

    task automatic acc(input logic w, input logic [2:0] z);
        int k;
        lead_n = 0;
        act_n = 0;
        trail_n = 0;
        dir_n = 0;
        cs_seen = '0;
        acc_write <= w;
        acc_zone <= z;
        acc_req <= 1'b1;
        @(posedge clk_sys);
        acc_req <= 1'b0;
        k = 0;
        while (acc_done !== 1'b1 && k < 300) begin
            @(posedge clk_sys);
            k++;
        end
        chk("done", 1, acc_done);
    endtask

    task automatic chk_acc(input int l, a, t, d, input logic [7:0] m);
        chk("lead", l, lead_n);
        chk("active", a, act_n);
        chk("trail", t, trail_n);
        chk("strobe", d, dir_n);
        chk("select", {24'h0, m}, {24'h0, cs_seen});
    endtask

    task automatic t_regs();
        wb(0, EBZT_OFS_TIMING0 + 8'h0c, 0);
        chk("timing3", {15'h0, EBZT_TIMING_RST}, rdat);
        wb(1, 8'h40, 32'hffffffff);
        wb(0, 8'h40, 0);
        chk("unmapped", 0, rdat);
    endtask

    task automatic t_plain();
        wb(1, 8'h04, tim(1, 0, 1, 1, 0, 1, 3'b000));
        wb(1, 8'h18, tim(1, 1, 1, 3, 7, 3, 3'b100));
        acc(0, 1);
        chk_acc(1, 1, 1, 1, 8'h02);
        acc(1, 6);
        chk_acc(6, 15, 6, 2, 8'h40);
        acc(0, 6);
        chk_acc(2, 3, 2, 1, 8'h40);
        acc(0, 1);
        chk_acc(1, 1, 1, 1, 8'h02);
    endtask

    task automatic t_wait(input logic w, input logic [2:0] m, input int a);
        acc(w, 4);
        chk("waits", 1, act_n > a);
        wb(0, EBZT_OFS_STATUS, 0);
        chk("status", act_n - a, rdat);
    endtask

    task automatic t_ready();
        stall_len <= 8'h08;
        wb(1, 8'h10, tim(2, 2, 0, 2, 2, 0, 3'b000));
        acc(1, 4);
        chk_acc(2, 3, 0, 2, 8'h10);
        wb(1, 8'h10, tim(2, 2, 0, 2, 2, 0, 3'b010));
        t_wait(0, 3'b010, 3);
        wb(1, 8'h10, tim(1, 2, 0, 1, 2, 0, 3'b011));
        t_wait(1, 3'b011, 3);
        stall_len <= 8'h00;
    endtask

    task automatic t_odd();
        wb(1, 8'h1c, tim(0, 0, 0, 0, 0, 0, 3'b000));
        acc(0, 7);
        chk_acc(0, 1, 0, 1, 8'h80);
        wb(1, EBZT_OFS_CTRL, 32'h00000001);
        acc(0, 1);
        chk_acc(2, 2, 2, 1, 8'h02);
        wb(1, EBZT_OFS_CTRL, 32'h00000000);
    endtask

    initial begin
        rst_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, acc_req, acc_write} = '0;
        wb_adr_i = '0;
        wb_sel_i = 4'hf;
        wb_dat_i = '0;
        acc_zone = '0;
        stall_len = '0;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_plain();
        t_ready();
        t_odd();
        close_out();
    end
endmodule
